// >>> dcis_cnt_pair.sv
/*
  shared constants of the integration scaler, and one pair of
  32-bit pulse counters (signal count and reference count).
  assumes pulse edges and clear arrive synchronous to the core clock.
*/
`timescale 1ns/10ps

package dcis_pkg;
  // data widths
  localparam int DCIS_WORD_W = 32;
  localparam int DCIS_QUAD_W = 34;
  localparam int DCIS_DIFF_W = 35;
  localparam int DCIS_COEF_W = 14;
  localparam int DCIS_PROD_W = 50;
  // converter full-scale options and gain settings
  localparam int DCIS_NUM_FS = 3;
  localparam int DCIS_NUM_GAIN = 10;
  localparam int DCIS_NUM_COEF = 30;
  localparam int DCIS_FS_HZ [0:2] = '{100000, 500000, 1000000};
  localparam int DCIS_VFC_DIV = 10;
  localparam int DCIS_GAIN_VAL [0:9] =
    '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000};
  // arithmetic scaling
  localparam int DCIS_QUAD_MUL = 4;
  localparam int DCIS_UNIT_SCALE = 100000000;
  localparam int DCIS_COEF_FRAC = 2;
  // triggers closer than this many cycles lose the capture
  localparam int DCIS_MIN_TRIG_GAP_CYC = 3;
  // reset values
  localparam logic [31:0] DCIS_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] DCIS_RES_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    DCIS_ST_IDLE = 3'h1,
    DCIS_ST_SUB = 3'h2,
    DCIS_ST_SCALE = 3'h4
  } dcis_state_t;

  typedef logic [13:0] dcis_coef_tab_t [0:29];

  // coefficient held times four, so every entry is a whole number
  function automatic dcis_coef_tab_t dcis_build_tab();
    dcis_coef_tab_t tab;
    int c;
    for (int f = 0; f < DCIS_NUM_FS; f++) begin
      c = DCIS_FS_HZ[f] / DCIS_VFC_DIV;
      for (int g = 0; g < DCIS_NUM_GAIN; g++) begin
        tab[f * DCIS_NUM_GAIN + g] = 14'((DCIS_UNIT_SCALE *
          (2 ** DCIS_COEF_FRAC)) / (DCIS_QUAD_MUL * c * DCIS_GAIN_VAL[g]));
      end
    end
    return tab;
  endfunction

  localparam dcis_coef_tab_t DCIS_COEF_TAB = dcis_build_tab();
endpackage

////////////////////////////////////////////////////////////////////////

module dcis_cnt_pair (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_count_en,
  input wire logic i_clear,
  // pulse edges
  input wire logic i_sig_edge,
  input wire logic i_ref_edge,
  // counts
  output logic [31:0] o_sig_cnt,
  output logic [31:0] o_ref_cnt
);
  typedef struct packed {
    logic [31:0] sig;
    logic [31:0] refc;
  } dcis_pair_st_t;

  dcis_pair_st_t st_r;
  dcis_pair_st_t st_nxt;

  // clear, or count both trains together while active
  always_comb begin
    st_nxt = st_r;
    if (i_clear) begin
      st_nxt.sig = dcis_pkg::DCIS_CNT_RST;
      st_nxt.refc = dcis_pkg::DCIS_CNT_RST;
    end else if (i_count_en) begin
      if (i_sig_edge) begin
        st_nxt.sig = st_r.sig + 32'h0000_0001;
      end
      if (i_ref_edge) begin
        st_nxt.refc = st_r.refc + 32'h0000_0001;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sig_cnt = st_r.sig;
  assign o_ref_cnt = st_r.refc;
endmodule

// >>> dcis_top.sv
/*
  dual counter integration scaler: two alternating counter pairs, the
  quadruple-and-subtract step and the coefficient scaling into a
  one-word result store.
  assumes all inputs synchronous to I_CORE_CLK and triggers at least
  a few cycles apart; pulse inputs are levels whose rising edges count.
*/
`timescale 1ns/10ps

// Overview of operation
// - results are signed 32-bit integers in units of 1e-8 volt-seconds
// - full-scale is 100 kHz, 500 kHz or 1 MHz, given by a code
// - active pair counts signal and reference trains together
// - each trigger swaps pairs and hands finished counts to arithmetic unless it is busy
// - first step multiplies the signal count by four
// - second step subtracts reference count and stores the difference
// - third step multiplies difference by 1e8 over 4 times C times G
// - thirty fixed coefficients chosen by converter constant and gain
// - scaled result is held until the host takes it
// - converter constant equals full-scale divided by ten
// - counts, gain and full-scale code are taken before each result
// - counters are 32 bits; signal signed, reference unsigned
// - idle pair is cleared after its counts are taken
module dcis_top (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // converter pulse trains and trigger
  input wire logic I_SIG_PULSE,
  input wire logic I_REF_PULSE,
  input wire logic I_TRIGGER,
  // measuring configuration
  input wire logic [1:0] I_FS_CODE,
  input wire logic [3:0] I_GAIN_CODE,
  // host side
  input wire logic I_RES_ACK,
  input wire logic I_OVR_CLR,
  output logic [31:0] O_RESULT,
  output logic O_RESULT_VALID,
  output logic O_ACTIVE_PAIR,
  output logic O_BUSY,
  output logic O_OVERRUN
);
  typedef struct packed {
    logic active;
    logic trig_prev;
    logic sig_prev;
    logic ref_prev;
    logic trig_d;
    logic clr;
    dcis_pkg::dcis_state_t st;
    logic [33:0] quad;
    logic [31:0] refc;
    logic [34:0] diff;
    logic [3:0] gain;
    logic [1:0] fs;
    logic [31:0] result;
    logic valid;
    logic busy;
    logic overrun;
  } dcis_top_st_t;

  dcis_top_st_t st_r;
  dcis_top_st_t st_nxt;

  logic trig_rise;
  logic sig_rise;
  logic ref_rise;
  logic [31:0] a_sig;
  logic [31:0] a_ref;
  logic [31:0] b_sig;
  logic [31:0] b_ref;
  logic [31:0] idle_sig;
  logic [31:0] idle_ref;
  logic [13:0] coef_w;
  logic [34:0] quad_ext;
  logic [34:0] ref_ext;
  logic signed [49:0] prod_w;
  logic signed [49:0] adj_w;
  logic [31:0] scaled_w;
  logic store_w;

  ////////////////////////////////////////////////////////////////////
  // coefficient lookup by full-scale code and gain code

  function automatic logic [13:0] dcis_coef(input logic [1:0] fs,
                                            input logic [3:0] gain);
    int idx;
    idx = int'(fs) * dcis_pkg::DCIS_NUM_GAIN + int'(gain);
    if ((int'(fs) < dcis_pkg::DCIS_NUM_FS) &&
        (int'(gain) < dcis_pkg::DCIS_NUM_GAIN)) begin
      return dcis_pkg::DCIS_COEF_TAB[idx];
    end
    return 14'h0000;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // edge detection and counter pairs

  assign trig_rise = I_TRIGGER & ~st_r.trig_prev;
  assign sig_rise = I_SIG_PULSE & ~st_r.sig_prev;
  assign ref_rise = I_REF_PULSE & ~st_r.ref_prev;

  // pair a counts while active is low, pair b while it is high
  dcis_cnt_pair u_pair_a (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_count_en(~st_r.active),
    .i_clear(st_r.clr & st_r.active),
    .i_sig_edge(sig_rise),
    .i_ref_edge(ref_rise),
    .o_sig_cnt(a_sig),
    .o_ref_cnt(a_ref)
  );

  dcis_cnt_pair u_pair_b (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_count_en(st_r.active),
    .i_clear(st_r.clr & ~st_r.active),
    .i_sig_edge(sig_rise),
    .i_ref_edge(ref_rise),
    .o_sig_cnt(b_sig),
    .o_ref_cnt(b_ref)
  );

  // the pair that is not counting
  assign idle_sig = st_r.active ? a_sig : b_sig;
  assign idle_ref = st_r.active ? a_ref : b_ref;

  ////////////////////////////////////////////////////////////////////
  // arithmetic

  assign quad_ext = {st_r.quad[33], st_r.quad};
  assign ref_ext = {3'h0, st_r.refc};
  assign coef_w = dcis_coef(st_r.fs, st_r.gain);
  assign prod_w = 50'($signed(st_r.diff)) * 50'($signed({1'b0, coef_w}));
  // round toward zero before dropping the two fraction bits
  assign adj_w = prod_w + (prod_w[49] ? 50'sh3 : 50'sh0);
  assign scaled_w = adj_w[33:2];
  assign store_w = (st_r.st == dcis_pkg::DCIS_ST_SCALE) &&
                   (!st_r.valid || I_RES_ACK);

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.trig_prev = I_TRIGGER;
    st_nxt.sig_prev = I_SIG_PULSE;
    st_nxt.ref_prev = I_REF_PULSE;
    st_nxt.trig_d = trig_rise;
    // idle pair cleared one cycle after its counts are taken
    st_nxt.clr = st_r.trig_d;
    if (trig_rise) begin
      st_nxt.active = ~st_r.active;
    end
    if (I_RES_ACK) begin
      st_nxt.valid = 1'b0;
    end
    if (I_OVR_CLR) begin
      st_nxt.overrun = 1'b0;
    end
    unique case (st_r.st)
      dcis_pkg::DCIS_ST_IDLE: begin
        if (st_r.trig_d) begin
          st_nxt.quad = {idle_sig, 2'b00};
          st_nxt.refc = idle_ref;
          st_nxt.gain = I_GAIN_CODE;
          st_nxt.fs = I_FS_CODE;
          st_nxt.st = dcis_pkg::DCIS_ST_SUB;
        end
      end
      dcis_pkg::DCIS_ST_SUB: begin
        st_nxt.diff = quad_ext - ref_ext;
        st_nxt.st = dcis_pkg::DCIS_ST_SCALE;
      end
      dcis_pkg::DCIS_ST_SCALE: begin
        // waits here while the previous result is still unread
        if (store_w) begin
          st_nxt.result = scaled_w;
          st_nxt.valid = 1'b1;
          st_nxt.st = dcis_pkg::DCIS_ST_IDLE;
        end
      end
      default: begin
        st_nxt.st = dcis_pkg::DCIS_ST_IDLE;
      end
    endcase
    // a capture missed while busy sets the sticky flag; set wins
    if (st_r.trig_d && (st_r.st != dcis_pkg::DCIS_ST_IDLE)) begin
      st_nxt.overrun = 1'b1;
    end
    st_nxt.busy = (st_nxt.st != dcis_pkg::DCIS_ST_IDLE);
  end

  // state register
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_r <= '{st: dcis_pkg::DCIS_ST_IDLE,
                result: dcis_pkg::DCIS_RES_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign O_RESULT = st_r.result;
  assign O_RESULT_VALID = st_r.valid;
  assign O_ACTIVE_PAIR = st_r.active;
  assign O_BUSY = st_r.busy;
  assign O_OVERRUN = st_r.overrun;

  ////////////////////////////////////////////////////////////////////
  // checks

  pair_switch_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    trig_rise |=> (st_r.active != $past(st_r.active)))
    else $error("pair not swapped on trigger");

  capture_quad_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    st_r.trig_d && (st_r.st == dcis_pkg::DCIS_ST_IDLE) |=>
    (st_r.st == dcis_pkg::DCIS_ST_SUB) &&
    (st_r.quad == {$past(idle_sig), 2'b00}) &&
    (st_r.refc == $past(idle_ref)))
    else $error("capture or quadruple wrong");

  sub_diff_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st_r.st == dcis_pkg::DCIS_ST_SUB) |=>
    (st_r.st == dcis_pkg::DCIS_ST_SCALE) &&
    (st_r.diff == $past(quad_ext) - $past(ref_ext)))
    else $error("difference wrong");

  idle_clear_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    st_r.trig_d && !trig_rise ##1 !trig_rise |=>
    (idle_sig == 32'h0000_0000) && (idle_ref == 32'h0000_0000))
    else $error("idle pair not cleared");

  idle_frozen_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    !st_r.clr && !trig_rise |=>
    (idle_sig == $past(idle_sig)) && (idle_ref == $past(idle_ref)))
    else $error("idle pair moved");

  result_hold_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    st_r.valid && !I_RES_ACK |=> st_r.valid && $stable(st_r.result))
    else $error("unread result lost");

  scale_store_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    store_w |=> st_r.valid && (st_r.st == dcis_pkg::DCIS_ST_IDLE))
    else $error("scaled result not stored");

  coef_table_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (st_r.st == dcis_pkg::DCIS_ST_SCALE) && (st_r.fs < 2'h3) &&
    (st_r.gain < 4'hA) |->
    (int'(coef_w) * (dcis_pkg::DCIS_FS_HZ[st_r.fs] / 10) *
     dcis_pkg::DCIS_GAIN_VAL[st_r.gain] == dcis_pkg::DCIS_UNIT_SCALE))
    else $error("coefficient mismatch");

  overrun_a: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    st_r.trig_d && (st_r.st != dcis_pkg::DCIS_ST_IDLE) |=> st_r.overrun)
    else $error("missed capture not flagged");
endmodule

// >>> dcis_vfc_model.sv
/*
  behavioural converter model: signal and reference pulse trains.
  assumes the bench sets the signal period and the full-scale code.
*/
`timescale 1ns/10ps

module dcis_vfc_model (
  // clock
  input wire logic i_clk,
  // settings from the bench
  input wire logic [1:0] i_fs_code,
  input wire logic [15:0] i_sig_per,
  // pulse trains
  output logic o_sig_pulse,
  output logic o_ref_pulse
);
  int ref_per;
  int sc = 0;
  int rc = 0;

  // reference period in cycles, twice full-scale rate
  always_comb begin
    ref_per = 100000000 / (2 * dcis_pkg::DCIS_FS_HZ[(i_fs_code > 2'h2) ?
      2 : int'(i_fs_code)]);
  end

  ////////////////////////////////////////////////////////////////////////
  // free running period counters
  always @(posedge i_clk) begin
    sc <= (sc + 1 >= int'(i_sig_per)) ? 0 : sc + 1;
    rc <= (rc + 1 >= ref_per) ? 0 : rc + 1;
  end

  // square waves, high for the first half of each period
  assign o_sig_pulse = sc < int'(i_sig_per) / 2;
  assign o_ref_pulse = rc < ref_per / 2;
endmodule

// >>> test_dcis_top.sv
/*
  self-checking bench: walks all valid full-scale and gain codes, compares
  each result with an integer model of the counts.
  assumes the converter model file and the design are compiled first.
*/
`timescale 1ns/10ps

module test_dcis_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trig = 1'b0;
  logic ack = 1'b0;
  logic oclr = 1'b0;
  logic [1:0] fs = 2'h2;
  logic [3:0] gain = 4'h0;
  logic [15:0] sig_per = 16'h0064;
  logic sig_p, ref_p, valid, pair, busy, ovr;
  logic [31:0] result;
  logic exp_pair = 1'b0;
  logic sp, rp, tp;
  longint n_cnt, nr_cnt, cap_n, cap_nr;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  dcis_vfc_model partner (.i_clk(clk), .i_fs_code(fs),
    .i_sig_per(sig_per), .o_sig_pulse(sig_p), .o_ref_pulse(ref_p));

  dcis_top uut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_SIG_PULSE(sig_p),
    .I_REF_PULSE(ref_p), .I_TRIGGER(trig), .I_FS_CODE(fs),
    .I_GAIN_CODE(gain), .I_RES_ACK(ack), .I_OVR_CLR(oclr),
    .O_RESULT(result), .O_RESULT_VALID(valid), .O_ACTIVE_PAIR(pair),
    .O_BUSY(busy), .O_OVERRUN(ovr));

  ////////////////////////////////////////////////////////////////////////
  // reference count of pulse edges per trigger interval
  always @(posedge clk) begin
    if (rst) begin
      n_cnt = 0;
      nr_cnt = 0;
      sp = 1'b0;
      rp = 1'b0;
      tp = 1'b0;
    end else begin
      n_cnt += (sig_p && !sp);
      nr_cnt += (ref_p && !rp);
      if (trig && !tp) begin
        cap_n = n_cnt;
        cap_nr = nr_cnt;
        n_cnt = 0;
        nr_cnt = 0;
      end
      sp = sig_p;
      rp = ref_p;
      tp = trig;
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // expected scaled result, invalid codes give zero
  function automatic logic [31:0] exp_res(longint n, longint nr, int f,
                                          int g);
    longint c, k4, p;
    if (f > 2 || g > 9) begin
      return 32'h0000_0000;
    end
    c = dcis_pkg::DCIS_FS_HZ[f] / 10;
    k4 = 400000000 / (4 * c * dcis_pkg::DCIS_GAIN_VAL[g]);
    p = (4 * n - nr) * k4 / 4;
    return p[31:0];
  endfunction

  // one comparison
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one measuring interval, trigger, result and host handshake
  task automatic run(input int f, input int g);
    int refp, len, w;
    logic [31:0] exp;
    refp = 100000000 / (2 * dcis_pkg::DCIS_FS_HZ[(f > 2) ? 2 : f]);
    @(posedge clk);
    fs <= f[1:0];
    gain <= g[3:0];
    sig_per <= 16'(2 * refp + $urandom % (6 * refp));
    len = 6 * refp + $urandom % (4 * refp);
    repeat (len) @(posedge clk);
    trig <= 1'b1;
    exp_pair = ~exp_pair;
    @(posedge clk);
    trig <= 1'b0;
    @(posedge clk);
    #1;
    check("pair", {31'h0, pair}, {31'h0, exp_pair});
    check("busy", {31'h0, busy}, 32'h0000_0001);
    w = 0;
    while (valid !== 1'b1 && w < 20) begin
      @(posedge clk);
      #1;
      w++;
    end
    exp = exp_res(cap_n, cap_nr, f, g);
    check("result", result, exp);
    check("done busy", {31'h0, busy}, 32'h0000_0000);
    repeat (3) @(posedge clk);
    #1;
    check("held", result, exp);
    check("held valid", {31'h0, valid}, 32'h0000_0001);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    #1;
    check("taken", {31'h0, valid}, 32'h0000_0000);
    check("no overrun", {31'h0, ovr}, 32'h0000_0000);
  endtask

  // one trigger pulse, high for one cycle
  task automatic fire();
    @(posedge clk);
    trig <= 1'b1;
    exp_pair = ~exp_pair;
    @(posedge clk);
    trig <= 1'b0;
  endtask

  // unread result stalls the next result store; a third trigger still swaps pairs but its capture is dropped
  task automatic overrun_case();
    logic [31:0] exp_a;
    logic [31:0] exp_b;
    @(posedge clk);
    fs <= 2'h2;
    gain <= 4'h4;
    repeat (400) @(posedge clk);
    fire();
    repeat (10) @(posedge clk);
    #1;
    exp_a = exp_res(cap_n, cap_nr, 2, 4);
    check("first", result, exp_a);
    repeat (400) @(posedge clk);
    fire();
    repeat (10) @(posedge clk);
    #1;
    exp_b = exp_res(cap_n, cap_nr, 2, 4);
    check("stall busy", {31'h0, busy}, 32'h0000_0001);
    check("unread", result, exp_a);
    repeat (400) @(posedge clk);
    fire();
    repeat (3) @(posedge clk);
    #1;
    check("overrun", {31'h0, ovr}, 32'h0000_0001);
    check("pair", {31'h0, pair}, {31'h0, exp_pair});
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1;
    check("late", result, exp_b);
    check("late valid", {31'h0, valid}, 32'h0000_0001);
    check("late busy", {31'h0, busy}, 32'h0000_0000);
    @(posedge clk);
    ack <= 1'b1;
    oclr <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    oclr <= 1'b0;
    @(posedge clk);
    #1;
    check("emptied", {31'h0, valid}, 32'h0000_0000);
    check("ovr cleared", {31'h0, ovr}, 32'h0000_0000);
  endtask

  // closing report
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: every full-scale and gain code, then invalid codes
  initial begin
    void'($urandom(32'hf94c3ce2));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      for (int g = 0; g < 10; g++) begin
        run(f, g);
      end
    end
    run(3, 3);
    run(1, 12);
    overrun_case();
    stop_test();
  end
endmodule
